// ==== rtl/sld_regs.vh ====
// register map, field positions, reset values and timing counts for loop diagnostics
`ifndef SLD_REGS_VH
`define SLD_REGS_VH
// apb byte offsets
`define SLD_REQ_ADDR      12'h000
`define SLD_STAT_ADDR     12'h004
`define SLD_CTRL_ADDR     12'h008
`define SLD_RESULT_ADDR   12'h00C
`define SLD_IRQ_STAT_ADDR 12'h010
`define SLD_IRQ_EN_ADDR   12'h014
`define SLD_IRQ_CLR_ADDR  12'h018
// loop_diag_request fields
`define SLD_REQ_SRC_EN    0
`define SLD_REQ_SRC_PIN   1
`define SLD_REQ_SNK_EN    2
`define SLD_REQ_MON_EN    3
`define SLD_REQ_MON_PIN   4
`define SLD_REQ_PD_DIS    5
`define SLD_REQ_LEVEL     6
`define SLD_REQ_HIRES     7
`define SLD_REQ_CH_LO     8
`define SLD_REQ_CH_HI     10
`define SLD_REQ_AUTO      12
`define SLD_REQ_MODE_LO   13
`define SLD_REQ_MODE_HI   14
`define SLD_REQ_RESET     32'h0000_0000
// auto flow modes
`define SLD_MODE_LEAK     2'h0
`define SLD_MODE_RES      2'h1
`define SLD_MODE_HIRES    2'h2
// conversion request codes
`define SLD_CONV_NONE     3'h0
`define SLD_CONV_FEED     3'h1
`define SLD_CONV_RETURN   3'h2
`define SLD_CONV_DIFF     3'h3
// interrupt bits
`define SLD_IRQ_CONV      0
`define SLD_IRQ_AUTO      1
`define SLD_IRQ_BITS      2
// timing
`define SLD_ADC_BITS      10
`define SLD_SETTLE_US     100
`define SLD_CLK_MHZ       100
`define SLD_SETTLE_CYC    (`SLD_SETTLE_US * `SLD_CLK_MHZ)
`define SLD_ADC_TOUT_CYC  16'h0400
`endif

// ==== rtl/sld_ctrl.v ====
// squib loop diagnostic control: switch steering, auto sequencer, converter hand-off
// Function
// - every analog result goes through one 10-bit converter, readable over bus
// - automatic flow: state machine sequences and times steps without host commands
// - leakage monitor selectable on feed pin or return pin of each channel
// - oxide check: source on chosen feed pin, feed voltage conversion accepted
// - battery-short check: source and monitor on feed, sink and pulldown off
// - ground-short check: sink and monitor on return, source and pulldown off
// - monitor connected turns off pulldown on that channel return pin
// - short flags follow comparators live, unlatched, need no conversion
// - status shows channel and pin side under leakage test
// - other return pin pulldowns stay on during ordinary leakage test
// - pulldown disable bit turns off every return pin pulldown
// - resistance step one: source on feed, sink on return of channel
// - source level select picks one of two nominal source currents
// - bypass step: source routed to return pin with sink kept on
// - each step result returned on matching conversion request code
// - high resistance: monitor on feed, sink on return, two thresholds
// - upper and lower high resistance flags report comparators live
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "sld_regs.vh"
module sld_ctrl #(
  parameter SETTLE_CYC = `SLD_SETTLE_CYC    // step settle time in cycles
) (
  input  wire        clk_in,            // 100 MHz clock
  input  wire        nrst_in,           // synchronous reset, active low
  input  wire        ce_in,             // clock enable, freezes state when low
  input  wire        psel_in,           // apb select
  input  wire        penable_in,        // apb enable
  input  wire        pwrite_in,         // apb direction
  input  wire [11:0] paddr_in,          // apb byte address
  input  wire [31:0] pwdata_in,         // apb write data
  output wire        pready_out,        // apb ready
  output reg  [31:0] prdata_out,        // apb read data
  output wire        pslverr_out,       // apb error
  input  wire        batt_cmp_in,       // battery_short_comparator output, async
  input  wire        gnd_cmp_in,        // ground_short_comparator output, async
  input  wire        hires_hi_cmp_in,   // upper high resistance comparator, async
  input  wire        hires_lo_cmp_in,   // lower high resistance comparator, async
  output reg  [7:0]  src_feed_out,      // test_current_source onto loop_feed_pin
  output reg  [7:0]  src_ret_out,       // test_current_source onto loop_return_pin
  output reg         src_level_out,     // source_level_select, 1 high current
  output reg  [7:0]  snk_ret_out,       // limited_sink_switch onto loop_return_pin
  output reg  [7:0]  mon_feed_out,      // regulated_current_monitor onto feed pin
  output reg  [7:0]  mon_ret_out,       // regulated_current_monitor onto return pin
  output reg  [7:0]  pulldown_en_out,   // return pin pulldown generators
  output reg         adc_start_out,     // converter start pulse
  output reg  [2:0]  adc_sel_out,       // converter input selection
  input  wire        adc_done_in,       // converter done, same clock
  input  wire [9:0]  adc_data_in,       // converter code
  output wire        irq_out            // level interrupt
);
  // auto sequencer states, one-hot
  localparam ST_IDLE  = 4'b0001;
  localparam ST_STEP1 = 4'b0010;
  localparam ST_STEP2 = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  reg  [31:0] req_r;                    // loop_diag_request
  reg  [2:0]  conv_code_r;              // diag_control_command conversion code
  reg  [9:0]  result_r;                 // last conversion code
  reg  [9:0]  result2_r;                // auto flow second step result
  reg         conv_busy_r;
  reg  [15:0] adc_tout_r;
  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [31:0] timer_r;
  reg  [`SLD_IRQ_BITS-1:0] irq_stat_r;
  reg  [`SLD_IRQ_BITS-1:0] irq_en_r;
  reg  [3:0]  sync1_r;
  reg  [3:0]  sync2_r;
  reg  [3:0]  sync3_r;
  reg  [3:0]  cmp_r;                    // filtered comparators
  wire        wr_en;
  wire        rd_en;
  wire        addr_ok;
  wire [2:0]  ch;
  wire        auto_on;
  wire [1:0]  mode;
  reg         ev_conv;
  wire        ev_auto;
  reg         auto_conv_req;
  reg  [2:0]  auto_conv_code;
  reg         step_src_feed;
  reg         step_src_ret;
  reg         step_snk;
  reg         step_mon;
  reg         step_mon_ret;

  // one-hot channel decode, used for every switch group
  function [7:0] sld_onehot;
    input [2:0] c;
    begin
      sld_onehot = 8'h01 << c;
    end
  endfunction

  assign ch      = req_r[`SLD_REQ_CH_HI:`SLD_REQ_CH_LO];
  assign auto_on = req_r[`SLD_REQ_AUTO];
  assign mode    = req_r[`SLD_REQ_MODE_HI:`SLD_REQ_MODE_LO];

  // apb slave: zero wait states, error on unmapped address
  assign pready_out = 1'b1;
  assign addr_ok = (paddr_in == `SLD_REQ_ADDR) || (paddr_in == `SLD_STAT_ADDR) ||
                   (paddr_in == `SLD_CTRL_ADDR) || (paddr_in == `SLD_RESULT_ADDR) ||
                   (paddr_in == `SLD_IRQ_STAT_ADDR) || (paddr_in == `SLD_IRQ_EN_ADDR) ||
                   (paddr_in == `SLD_IRQ_CLR_ADDR);
  assign pslverr_out = psel_in & penable_in & ~addr_ok;
  assign wr_en = psel_in & penable_in & pwrite_in & addr_ok & ce_in;
  assign rd_en = psel_in & penable_in & ~pwrite_in & addr_ok;

  // comparator synchroniser: accept change once stages two and three agree
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
      cmp_r   <= 4'h0;
    end else if (ce_in) begin
      sync1_r <= {hires_lo_cmp_in, hires_hi_cmp_in, gnd_cmp_in, batt_cmp_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      cmp_r   <= (sync2_r & sync3_r) | (cmp_r & (sync2_r | sync3_r));
    end
  end

  // request and control registers, software writes
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      req_r    <= `SLD_REQ_RESET;
      irq_en_r <= {`SLD_IRQ_BITS{1'b0}};
    end else if (ce_in) begin
      if (wr_en && paddr_in == `SLD_REQ_ADDR)
        req_r <= pwdata_in;
      else if (state_r == ST_DONE)
        req_r[`SLD_REQ_AUTO] <= 1'b0;          // auto run ends by itself
      if (wr_en && paddr_in == `SLD_IRQ_EN_ADDR)
        irq_en_r <= pwdata_in[`SLD_IRQ_BITS-1:0];
    end
  end

  // auto sequencer next state, steps timed internally
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (auto_on) state_nxt = ST_STEP1;
      ST_STEP1: if (!auto_on) state_nxt = ST_IDLE;
                else if (ev_conv) state_nxt = (mode == `SLD_MODE_RES) ? ST_STEP2 : ST_DONE;
      ST_STEP2: if (!auto_on) state_nxt = ST_IDLE;
                else if (ev_conv) state_nxt = ST_DONE;
      ST_DONE:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // auto step switch settings and conversion selection
  always @* begin
    step_src_feed  = 1'b0;
    step_src_ret   = 1'b0;
    step_snk       = 1'b0;
    step_mon       = 1'b0;
    step_mon_ret   = 1'b0;
    auto_conv_code = `SLD_CONV_NONE;
    case (mode)
      `SLD_MODE_RES: begin
        step_snk       = 1'b1;
        step_src_feed  = (state_r == ST_STEP1);
        step_src_ret   = (state_r == ST_STEP2);
        auto_conv_code = `SLD_CONV_DIFF;
      end
      `SLD_MODE_HIRES: begin
        step_mon       = 1'b1;
        step_snk       = 1'b1;
        auto_conv_code = `SLD_CONV_FEED;
      end
      default: begin
        step_mon       = 1'b1;
        step_mon_ret   = req_r[`SLD_REQ_MON_PIN];
        auto_conv_code = step_mon_ret ? `SLD_CONV_RETURN : `SLD_CONV_FEED;
      end
    endcase
    auto_conv_req = ((state_r == ST_STEP1) || (state_r == ST_STEP2)) &&
                    (timer_r == SETTLE_CYC - 1) && !conv_busy_r && !ev_conv;
  end

  // sequencer state and settle timer
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= ST_IDLE;
      timer_r <= 32'h0000_0000;
    end else if (ce_in) begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        timer_r <= 32'h0000_0000;
      else if (timer_r != SETTLE_CYC - 1)
        timer_r <= timer_r + 32'h0000_0001;
    end
  end

  // switch outputs: manual fields, or auto step when running
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      src_feed_out    <= 8'h00;
      src_ret_out     <= 8'h00;
      src_level_out   <= 1'b0;
      snk_ret_out     <= 8'h00;
      mon_feed_out    <= 8'h00;
      mon_ret_out     <= 8'h00;
      pulldown_en_out <= 8'hFF;
    end else if (ce_in) begin
      src_level_out <= req_r[`SLD_REQ_LEVEL];
      if (auto_on && state_r != ST_IDLE) begin
        src_feed_out <= step_src_feed ? sld_onehot(ch) : 8'h00;
        src_ret_out  <= step_src_ret ? sld_onehot(ch) : 8'h00;
        snk_ret_out  <= step_snk ? sld_onehot(ch) : 8'h00;
        mon_feed_out <= (step_mon && !step_mon_ret) ? sld_onehot(ch) : 8'h00;
        mon_ret_out  <= (step_mon && step_mon_ret) ? sld_onehot(ch) : 8'h00;
        pulldown_en_out <= req_r[`SLD_REQ_PD_DIS] ? 8'h00 :
                           (step_mon ? ~sld_onehot(ch) : 8'hFF);
      end else begin
        // source on feed (oxide, step one, battery check) or on return (bypass)
        src_feed_out <= (req_r[`SLD_REQ_SRC_EN] && !req_r[`SLD_REQ_SRC_PIN]) ?
                        sld_onehot(ch) : 8'h00;
        src_ret_out  <= (req_r[`SLD_REQ_SRC_EN] && req_r[`SLD_REQ_SRC_PIN]) ?
                        sld_onehot(ch) : 8'h00;
        snk_ret_out  <= req_r[`SLD_REQ_SNK_EN] ? sld_onehot(ch) : 8'h00;
        mon_feed_out <= (req_r[`SLD_REQ_MON_EN] && !req_r[`SLD_REQ_MON_PIN]) ?
                        sld_onehot(ch) : 8'h00;
        mon_ret_out  <= (req_r[`SLD_REQ_MON_EN] && req_r[`SLD_REQ_MON_PIN]) ?
                        sld_onehot(ch) : 8'h00;
        // monitor drops own pulldown, others stay on unless all disabled
        if (req_r[`SLD_REQ_PD_DIS])
          pulldown_en_out <= 8'h00;
        else if (req_r[`SLD_REQ_MON_EN])
          pulldown_en_out <= ~sld_onehot(ch);
        else
          pulldown_en_out <= 8'hFF;
      end
    end
  end

  // single converter, requested by code write or by sequencer
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      conv_code_r   <= `SLD_CONV_NONE;
      conv_busy_r   <= 1'b0;
      adc_start_out <= 1'b0;
      adc_sel_out   <= `SLD_CONV_NONE;
      adc_tout_r    <= 16'h0000;
      result_r      <= 10'h000;
      result2_r     <= 10'h000;
      ev_conv       <= 1'b0;
    end else if (ce_in) begin
      adc_start_out <= 1'b0;
      ev_conv       <= 1'b0;
      if (!conv_busy_r) begin
        // a new code starts a conversion; busy converter ignores new codes
        if (wr_en && paddr_in == `SLD_CTRL_ADDR &&
            pwdata_in[2:0] != `SLD_CONV_NONE) begin
          conv_code_r   <= pwdata_in[2:0];
          adc_sel_out   <= pwdata_in[2:0];
          adc_start_out <= 1'b1;
          conv_busy_r   <= 1'b1;
          adc_tout_r    <= 16'h0000;
        end else if (auto_conv_req) begin
          conv_code_r   <= auto_conv_code;
          adc_sel_out   <= auto_conv_code;
          adc_start_out <= 1'b1;
          conv_busy_r   <= 1'b1;
          adc_tout_r    <= 16'h0000;
        end
      end else if (adc_done_in || adc_tout_r == `SLD_ADC_TOUT_CYC) begin
        // timeout guards against a converter that never answers
        conv_busy_r <= 1'b0;
        ev_conv     <= 1'b1;
        if (state_r == ST_STEP2)
          result2_r <= adc_data_in;
        else
          result_r  <= adc_data_in;
      end else begin
        adc_tout_r <= adc_tout_r + 16'h0001;
      end
    end
  end

  // sticky interrupt flags; a new event beats a clear in the same cycle
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_stat_r <= {`SLD_IRQ_BITS{1'b0}};
    end else if (ce_in) begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && paddr_in == `SLD_IRQ_CLR_ADDR) ?
                     pwdata_in[`SLD_IRQ_BITS-1:0] : {`SLD_IRQ_BITS{1'b0}})) |
                    {ev_auto, ev_conv};
    end
  end
  assign ev_auto = (state_r == ST_DONE);
  assign irq_out = |(irq_stat_r & irq_en_r);

  // read mux; status flags are live comparator images, never latched
  always @* begin
    prdata_out = 32'h0000_0000;
    if (rd_en) begin
      case (paddr_in)
        `SLD_REQ_ADDR:      prdata_out = req_r;
        `SLD_STAT_ADDR:     prdata_out = {18'h0_0000, state_r, conv_busy_r,
                                          req_r[`SLD_REQ_MON_PIN], ch,
                                          req_r[`SLD_REQ_MON_EN],
                                          cmp_r[3], cmp_r[2],
                                          cmp_r[1], cmp_r[0]};
        `SLD_CTRL_ADDR:     prdata_out = {29'h0000_0000, conv_code_r};
        `SLD_RESULT_ADDR:   prdata_out = {6'h00, result2_r, 6'h00, result_r};
        `SLD_IRQ_STAT_ADDR: prdata_out = {30'h0000_0000, irq_stat_r};
        `SLD_IRQ_EN_ADDR:   prdata_out = {30'h0000_0000, irq_en_r};
        default:            prdata_out = 32'h0000_0000;
      endcase
    end
  end
endmodule // sld_ctrl

// ==== test/sld_checker.sv ====
// concurrent checks on the loop diagnostic control ports
`timescale 1ns/1ps
module sld_checker #(
  parameter SETTLE_CYC = 8      // auto step settle count
) (
  input wire        clk_in, nrst_in, ce_in, psel_in, penable_in, pwrite_in,  // clock, apb
  input wire [11:0] paddr_in,                                                // apb address
  input wire [31:0] pwdata_in, prdata_out,                                   // apb data
  input wire        pslverr_out, batt_cmp_in, gnd_cmp_in, hires_hi_cmp_in,   // error, flags
  input wire        hires_lo_cmp_in, src_level_out, adc_start_out, adc_done_in,
  input wire [7:0]  src_feed_out, src_ret_out, snk_ret_out, mon_feed_out, mon_ret_out,
  input wire [7:0]  pulldown_en_out,                                         // pulldowns
  input wire [2:0]  adc_sel_out                                              // converter input
);
  localparam int SET_LO = SETTLE_CYC - 2;
  localparam int SET_HI = SETTLE_CYC + 8;
  wire        acc    = psel_in & penable_in;
  wire        wr_ok  = acc & pwrite_in & ce_in;
  wire        req_wr = wr_ok & (paddr_in == 12'h000);
  wire        ctl_wr = wr_ok & (paddr_in == 12'h008) & (pwdata_in[2:0] != 3'h0);
  reg  [31:0] w_r;
  reg  [2:0]  code_r, stab_r;
  reg         idle_r;
  wire [2:0]  ch     = w_r[10:8];
  function automatic logic [7:0] hot(input logic en);
    return en ? (8'h01 << ch) : 8'h00;
  endfunction
  // last manual request, ctrl code, quiet time of comparators, converter idle
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      stab_r <= 3'h0;
      idle_r <= 1'b1;
    end else begin
      if (req_wr && !pwdata_in[12]) w_r <= pwdata_in;
      if (ctl_wr) code_r <= pwdata_in[2:0];
      if (!$stable({batt_cmp_in, gnd_cmp_in, hires_hi_cmp_in, hires_lo_cmp_in})) stab_r <= 3'h0;
      else if (stab_r != 3'h7) stab_r <= stab_r + 3'h1;
      if (adc_start_out) idle_r <= 1'b0;
      else if (adc_done_in) idle_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // a lone manual request write, so outputs have settled one cycle later
  sequence s_man_wr;
    req_wr && !pwdata_in[12] ##1 !req_wr;
  endsequence
  sequence s_stat_rd;
    acc && !pwrite_in && paddr_in == 12'h004 && stab_r == 3'h7;
  endsequence
  a_src_route: assert property (s_man_wr |=> src_feed_out == hot(w_r[0] & ~w_r[1])
    && src_ret_out == hot(w_r[0] & w_r[1])) else $error("source routing wrong");
  a_sink_route: assert property (s_man_wr |=> snk_ret_out == hot(w_r[2]))
    else $error("sink routing wrong");
  a_mon_route: assert property (s_man_wr |=> mon_feed_out == hot(w_r[3] & ~w_r[4])
    && mon_ret_out == hot(w_r[3] & w_r[4])) else $error("monitor routing wrong");
  a_pd_select: assert property (s_man_wr |=> pulldown_en_out ==
    (w_r[5] ? 8'h00 : w_r[3] ? ~hot(1'b1) : 8'hFF)) else $error("pulldown pattern wrong");
  a_level_sel: assert property (s_man_wr |=> src_level_out == w_r[6])
    else $error("source level wrong");
  a_flags_live: assert property (s_stat_rd |-> prdata_out[3:0] ==
    {hires_lo_cmp_in, hires_hi_cmp_in, gnd_cmp_in, batt_cmp_in}) else $error("flags stale");
  a_conv_start: assert property (ctl_wr && idle_r && !adc_start_out |=>
    adc_start_out && adc_sel_out == code_r) else $error("conversion not started");
  a_conv_refuse: assert property (ctl_wr && !idle_r |=> !adc_start_out)
    else $error("busy conversion restarted");
  a_start_pulse: assert property (adc_start_out |=> !adc_start_out) else $error("start too long");
  a_auto_settle: assert property (req_wr && pwdata_in[12] |-> ##[SET_LO:SET_HI] adc_start_out)
    else $error("auto step not timed");
  a_bus_error: assert property (acc |-> pslverr_out == (paddr_in > 12'h018))
    else $error("slave error wrong");
endmodule // sld_checker
bind sld_ctrl sld_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
  .batt_cmp_in(batt_cmp_in), .gnd_cmp_in(gnd_cmp_in), .hires_hi_cmp_in(hires_hi_cmp_in),
  .hires_lo_cmp_in(hires_lo_cmp_in), .src_level_out(src_level_out), .adc_start_out(adc_start_out),
  .adc_done_in(adc_done_in), .src_feed_out(src_feed_out), .src_ret_out(src_ret_out),
  .snk_ret_out(snk_ret_out), .mon_feed_out(mon_feed_out), .mon_ret_out(mon_ret_out),
  .pulldown_en_out(pulldown_en_out), .adc_sel_out(adc_sel_out));

// ==== test/sld_loop_model.sv ====
// behavioural loops, current comparators and converter facing the control block
`timescale 1ns/1ps
module sld_loop_model (
  input  wire       clk_in,                                     // system clock
  input  wire [7:0] src_feed_in, src_ret_in, snk_ret_in, pd_in, // switch states
  input  wire [7:0] mon_feed_in, mon_ret_in,                    // monitor routing
  input  wire       adc_start_in,                               // converter start
  input  wire [2:0] adc_sel_in,                                 // converter input
  input  wire       leak_batt_in, leak_gnd_in, short_in,        // injected faults
  input  wire [1:0] band_in,                                    // resistance band
  input  wire [9:0] base_in,                                    // code seed
  input  wire [7:0] delay_in,                                   // converter latency
  output wire       batt_out, gnd_out, hi_out, lo_out,          // comparators
  output reg        done_out = 1'b0,                            // converter done
  output reg  [9:0] data_out = 10'h000                          // converter code
);
  wire       mon  = |(mon_feed_in | mon_ret_in);
  wire       hr   = |(mon_feed_in & snk_ret_in);
  wire [9:0] code = base_in ^ {|src_ret_in, 6'h00, (adc_sel_in == 3'h3) ? 3'h0 : adc_sel_in};
  reg        busy_r = 1'b0;
  reg  [7:0] cnt_r = 8'h00;
  // a healthy monitor flags only its validation setups or a real fault
  assign batt_out = mon & ((|(mon_feed_in & src_feed_in) & ~|snk_ret_in) | leak_batt_in);
  assign gnd_out = mon & ((|(mon_ret_in & snk_ret_in) & ~|src_feed_in) | leak_gnd_in
    | (short_in & |pd_in));
  assign hi_out = hr & band_in[1];
  assign lo_out = hr & band_in[0];
  // data toggles outside the done cycle so a sample one cycle late never matches
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    data_out <= ~data_out;
    if (adc_start_in) begin
      busy_r <= 1'b1;
      cnt_r  <= delay_in;
    end else if (busy_r && cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    else if (busy_r) begin
      busy_r   <= 1'b0;
      done_out <= 1'b1;
      data_out <= code;
    end
  end
endmodule // sld_loop_model

// ==== test/tb_top.sv ====
// self-checking bench for the loop diagnostic control block
`timescale 1ns/1ps
`include "sld_regs.vh"
module tb_top;
  reg         clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1, psel_in = 1'b0;
  reg         penable_in = 1'b0, pwrite_in = 1'b0, lb_r = 1'b0, lg_r = 1'b0, sh_r = 1'b0;
  reg  [11:0] paddr_in = 12'h000;
  reg  [31:0] pwdata_in = 32'h0, seed_r = 32'h0000_004B;
  reg  [1:0]  band_r = 2'h0;
  reg  [9:0]  base_r = 10'h000;
  reg  [7:0]  dly_r = 8'h01;
  wire        pready_out, pslverr_out, src_level_out, adc_start_out, adc_done_in, irq_out;
  wire        batt_cmp_in, gnd_cmp_in, hires_hi_cmp_in, hires_lo_cmp_in;
  wire [31:0] prdata_out;
  wire [9:0]  adc_data_in;
  wire [2:0]  adc_sel_out;
  wire [7:0]  src_feed_out, src_ret_out, snk_ret_out, mon_feed_out, mon_ret_out, pulldown_en_out;
  logic [64:0] rd_q[$], e_r;
  logic [15:0] tab [9] = '{16'h0001, 16'h0009, 16'h001C,
    16'h0008, 16'h0018, 16'h0038, 16'h0045, 16'h0007, 16'h000C};
  int errors = 0, n_compared = 0;
  sld_ctrl #(.SETTLE_CYC(8)) u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out),
    .pslverr_out(pslverr_out), .batt_cmp_in(batt_cmp_in), .gnd_cmp_in(gnd_cmp_in),
    .hires_hi_cmp_in(hires_hi_cmp_in), .hires_lo_cmp_in(hires_lo_cmp_in),
    .src_feed_out(src_feed_out), .src_ret_out(src_ret_out), .src_level_out(src_level_out),
    .snk_ret_out(snk_ret_out), .mon_feed_out(mon_feed_out), .mon_ret_out(mon_ret_out),
    .pulldown_en_out(pulldown_en_out), .adc_start_out(adc_start_out), .adc_sel_out(adc_sel_out),
    .adc_done_in(adc_done_in), .adc_data_in(adc_data_in), .irq_out(irq_out));
  sld_loop_model u_loop (.clk_in(clk_in), .src_feed_in(src_feed_out), .src_ret_in(src_ret_out),
    .snk_ret_in(snk_ret_out), .pd_in(pulldown_en_out), .mon_feed_in(mon_feed_out),
    .mon_ret_in(mon_ret_out), .adc_start_in(adc_start_out), .adc_sel_in(adc_sel_out),
    .leak_batt_in(lb_r), .leak_gnd_in(lg_r), .short_in(sh_r), .band_in(band_r), .base_in(base_r),
    .delay_in(dly_r), .batt_out(batt_cmp_in), .gnd_out(gnd_cmp_in), .hi_out(hires_hi_cmp_in),
    .lo_out(hires_lo_cmp_in), .done_out(adc_done_in), .data_out(adc_data_in));
  always #5 clk_in = ~clk_in;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // one apb transfer, held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1 && n < 64) begin
      n++;
      @(posedge clk_in);
    end
    if (n == 64) errors++;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, m, input logic er);
    rd_q.push_back({m, er, x & m});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, s);
    n_compared++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_in);
    end
    chk("irq raised", 32'h1, {31'h0, irq_out});
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // oldest note against each completed read, sampled before the edge updates land
  always @(posedge clk_in) begin
    if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
      e_r = rd_q.pop_front();
      n_compared++;
      if ({pslverr_out, prdata_out & e_r[64:33]} !== e_r[32:0]) begin
        errors++;
        $display("CHECK FAILED read %h expected %h seen %h", paddr_in, e_r[32:0], prdata_out);
      end
    end
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    conclude;
  end
  initial begin : main
    logic [31:0] w, x;
    logic        fb, mf;
    int          i, p, c;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(`SLD_REQ_ADDR, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(`SLD_IRQ_EN_ADDR, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(`SLD_IRQ_CLR_ADDR, 32'h0, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
    rd(12'h01C, 32'h0, 32'hFFFF_FFFF, 1'b1);
    chk("pulldown reset", 32'hFF, {24'h0, pulldown_en_out});
    $display("test reset done");
    // every switch setup, twice with fresh faults and no conversion between reads
    for (i = 0; i < 9; i++) begin
      for (p = 0; p < 2; p++) begin
        seed_r = xs(seed_r);
        lb_r <= (p == 0) && seed_r[3];
        lg_r <= (p == 0) && seed_r[4];
        sh_r <= (p == 1);
        band_r <= seed_r[6:5];
        w = {16'h0, tab[i]} | {21'h0, seed_r[2:0], 8'h00};
        apb(1'b1, `SLD_REQ_ADDR, w);
        repeat (10) @(posedge clk_in);
        fb = w[0] & ~w[1];
        mf = w[3] & ~w[4];
        x = {23'h0, w[4], w[10:8], w[3], mf & w[2] & band_r[0], mf & w[2] & band_r[1],
          w[3] & ((w[4] & w[2] & ~fb) | lg_r | (sh_r & ~w[5])), w[3] & ((mf & fb & ~w[2]) | lb_r)};
        rd(`SLD_STAT_ADDR, x, 32'h0000_01FF, 1'b0);
      end
    end
    $display("test switches done");
    apb(1'b1, `SLD_IRQ_EN_ADDR, 32'h1);
    for (c = 1; c < 4; c++) begin
      seed_r = xs(seed_r);
      base_r <= seed_r[9:0];
      dly_r <= (c == 2) ? 8'h28 : 8'h01;
      apb(1'b1, `SLD_CTRL_ADDR, 32'(c));
      if (c == 2) apb(1'b1, `SLD_CTRL_ADDR, 32'h3);
      wait_irq;
      x = {22'h0, seed_r[9:0] ^ ((c == 3) ? 10'h0 : 10'(c))};
      rd(`SLD_RESULT_ADDR, x, 32'h3FF, 1'b0);
      rd(`SLD_IRQ_STAT_ADDR, 32'h1, 32'h3, 1'b0);
      apb(1'b1, `SLD_IRQ_CLR_ADDR, 32'h1);
      @(posedge clk_in);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
    end
    apb(1'b1, `SLD_IRQ_EN_ADDR, 32'h0);
    apb(1'b1, `SLD_CTRL_ADDR, 32'h1);
    repeat (12) @(posedge clk_in);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    rd(`SLD_IRQ_STAT_ADDR, 32'h1, 32'h3, 1'b0);
    apb(1'b1, `SLD_IRQ_CLR_ADDR, 32'h1);
    $display("test conversion done");
    // automatic resistance flow: step one then bypass, no host step commands
    apb(1'b1, `SLD_IRQ_EN_ADDR, 32'h2);
    seed_r = xs(seed_r);
    base_r <= seed_r[9:0];
    dly_r <= 8'h03;
    w = 32'h0000_3000 | {21'h0, seed_r[2:0], 8'h00};
    apb(1'b1, `SLD_REQ_ADDR, w);
    wait_irq;
    x = {6'h0, seed_r[9:0] ^ 10'h200, 6'h0, seed_r[9:0]};
    rd(`SLD_RESULT_ADDR, x, 32'h03F8_03F8, 1'b0);
    rd(`SLD_REQ_ADDR, w & 32'hFFFF_EFFF, 32'h0000_7FFF, 1'b0);
    rd(`SLD_IRQ_STAT_ADDR, 32'h2, 32'h2, 1'b0);
    apb(1'b1, `SLD_IRQ_CLR_ADDR, 32'h2);
    $display("test auto done");
    ce_in <= 1'b0;
    apb(1'b1, `SLD_REQ_ADDR, 32'h20);
    ce_in <= 1'b1;
    rd(`SLD_REQ_ADDR, w & 32'hFFFF_EFFF, 32'h0000_7FFF, 1'b0);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(`SLD_REQ_ADDR, 32'h0, 32'hFFFF_FFFF, 1'b0);
    chk("pulldown reset", 32'hFF, {24'h0, pulldown_en_out});
    $display("test freeze and reset done");
    conclude;
  end
endmodule // tb_top
